//--- sra_slave.sv
/*
  Two-wire serial slave giving an outside master byte access to the
  control/status space and the user store.
  Assumes scl and sda are asynchronous pins sampled by mclk (20 MHz),
  and that backup is an asynchronous level from the supply monitor,
  synchronised here like the pins.
*/
`timescale 1ns/10ps
// Functional notes
// - Write: start, ID, address, data, stop; ack
// - After write stop, return to standby
// - Keep sending while master acknowledges
// - Read data comes from internal pointer
// - Pointer advances after each sent byte
// - Pointer wraps to 00h after 2Fh, or after 7Fh in the user store
// - Serial port disabled during battery backup
// - Ack only the two accepted identifiers
// - Pointer starts at 00h on power-up
// - Bytes travel most significant bit first
module sra_slave (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic backup,
  output logic sda_out,
  output logic sda_oe_b,
  output sra_pkg::reg_req_s wr_req,
  output logic wr_strobe
);
  typedef enum {ST_IDLE, ST_ID, ST_ID_ACK, ST_ADDR, ST_ADDR_ACK,
                ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK} state_e;

  state_e state;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl_q;
  logic sda_q;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic rd;
  logic user;
  logic [7:0] ptr;
  logic [7:0] txbyte;
  logic [7:0] csr_rdata;
  logic [7:0] usr_rdata;
  logic mem_we;
  logic [2:0] bkp_s;
  logic backup_q;

  localparam logic [3:0] ACK_SLOT_C = sra_pkg::ACK_SLOT;

  // Three-stage sync; a level counts once stages two and three agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bkp_s <= 3'h0;
      backup_q <= 1'b0;
    end else begin
      scl_s <= {scl_s[1:0], scl};
      sda_s <= {sda_s[1:0], sda_in};
      // Supply monitor runs off its own timing, so filter it too
      bkp_s <= {bkp_s[1:0], backup};
      if (scl_s[1] == scl_s[2]) begin
        scl_q <= scl_s[2];
      end
      if (sda_s[1] == sda_s[2]) begin
        sda_q <= sda_s[2];
      end
      if (bkp_s[1] == bkp_s[2]) begin
        backup_q <= bkp_s[2];
      end
    end
  end

  logic scl_new;
  logic sda_new;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_new = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_q;
  assign sda_new = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_q;
  assign scl_rise = !scl_q && scl_new;
  assign scl_fall = scl_q && !scl_new;
  assign start_c = scl_q && scl_new && sda_q && !sda_new;
  assign stop_c = scl_q && scl_new && !sda_q && sda_new;

  function automatic logic [7:0] next_ptr(input logic [7:0] p,
                                          input logic u);
    logic [7:0] last;
    last = u ? sra_pkg::USER_LAST : sra_pkg::CSR_LAST;
    next_ptr = (p >= last) ? sra_pkg::PTR_RESET : 8'(p + 8'h01);
  endfunction

  function automatic logic id_match(input logic [6:0] id);
    id_match = (id == sra_pkg::ID_CSR) || (id == sra_pkg::ID_USER);
  endfunction

  // Byte-level state machine; bits shift on rising scl, MSB first
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      rd <= 1'b0;
      user <= 1'b0;
    end else if (backup_q) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
    end else if (start_c) begin
      state <= ST_ID; // also serves the repeated start
      bitcnt <= 4'h0;
    end else if (stop_c) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
    end else if (scl_rise) begin
      case (state)
        ST_ID, ST_ADDR, ST_DATA: begin
          shreg <= {shreg[6:0], sda_q};
          bitcnt <= 4'(bitcnt + 4'h1);
        end
        ST_TX: begin
          bitcnt <= 4'(bitcnt + 4'h1);
        end
        ST_TX_ACK: begin
          // Master ack low keeps the burst going
          state <= sda_q ? ST_IDLE : ST_TX;
          bitcnt <= 4'h0;
        end
        default: begin
          bitcnt <= bitcnt;
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        ST_ID: begin
          if (bitcnt == ACK_SLOT_C) begin
            if (id_match(shreg[7:1])) begin
              state <= ST_ID_ACK;
              rd <= shreg[0];
              user <= (shreg[7:1] == sra_pkg::ID_USER);
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR, ST_DATA: begin
          if (bitcnt == ACK_SLOT_C) begin
            state <= (state == ST_ADDR) ? ST_ADDR_ACK : ST_DATA_ACK;
          end
        end
        ST_TX: begin
          if (bitcnt == ACK_SLOT_C) begin
            state <= ST_TX_ACK;
          end
        end
        ST_ID_ACK: begin
          state <= rd ? ST_TX : ST_ADDR;
          bitcnt <= 4'h0;
        end
        ST_ADDR_ACK: begin
          state <= ST_DATA;
          bitcnt <= 4'h0;
        end
        ST_DATA_ACK: begin
          // One data byte per write; further bytes get no ack
          state <= ST_IDLE;
          bitcnt <= 4'h0;
        end
        default: begin
          bitcnt <= bitcnt;
        end
      endcase
    end
  end

  // Pointer: loaded by the address byte, stepped per sent byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= sra_pkg::PTR_RESET;
    end else if (!backup_q && scl_fall && state == ST_ADDR
                 && bitcnt == ACK_SLOT_C) begin
      ptr <= shreg;
    end else if (!backup_q && scl_fall && state == ST_TX
                 && bitcnt == ACK_SLOT_C) begin
      ptr <= next_ptr(ptr, user);
    end
  end

  // Write strobe on the data byte's acknowledge
  assign mem_we = !backup_q && scl_fall && state == ST_DATA
                  && bitcnt == ACK_SLOT_C;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_req <= '0;
      wr_strobe <= 1'b0;
    end else begin
      wr_strobe <= mem_we;
      if (mem_we) begin
        wr_req <= '{we: 1'b1, user: user, addr: ptr, wdata: shreg};
      end
    end
  end

  // Separate stores so each identifier sees its own space
  sra_mem #(.DEPTH(128), .AW(7)) u_csr (
    .mclk(mclk),
    .we(mem_we && !user),
    .waddr(ptr[6:0]),
    .wdata(shreg),
    .raddr(ptr[6:0]),
    .rdata(csr_rdata)
  );

  sra_mem #(.DEPTH(128), .AW(7)) u_usr (
    .mclk(mclk),
    .we(mem_we && user),
    .waddr(ptr[6:0]),
    .wdata(shreg),
    .raddr(ptr[6:0]),
    .rdata(usr_rdata)
  );

  // Transmit byte captured as a TX byte begins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txbyte <= 8'h00;
    end else if (state != ST_TX || (bitcnt == 4'h0 && !scl_q)) begin
      txbyte <= user ? usr_rdata : csr_rdata;
    end
  end

  // Drive sda low only; enable is active low. Changes while scl is low.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out <= 1'b1;
      sda_oe_b <= 1'b1;
    end else if (backup_q || state == ST_IDLE) begin
      sda_out <= 1'b1;
      sda_oe_b <= 1'b1;
    end else if (!scl_q) begin
      case (state)
        ST_ID_ACK, ST_ADDR_ACK, ST_DATA_ACK: begin
          sda_out <= 1'b0;
          sda_oe_b <= 1'b0;
        end
        ST_TX: begin
          sda_out <= 1'b0;
          sda_oe_b <= (bitcnt < ACK_SLOT_C) ?
                      txbyte[3'(3'h7 - bitcnt[2:0])] : 1'b1;
        end
        default: begin
          sda_out <= 1'b1;
          sda_oe_b <= 1'b1;
        end
      endcase
    end
  end
endmodule

//--- sra_pkg.sv
/*
  Package for the two-wire register access slave: identifiers, pointer
  limits, byte layout and the carrier struct for register traffic.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sra_pkg;
  localparam logic [6:0] ID_CSR = 7'h6F;
  localparam logic [6:0] ID_USER = 7'h57;
  localparam logic [7:0] CSR_LAST = 8'h2F;
  localparam logic [7:0] USER_LAST = 8'h7F;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  typedef struct packed {
    logic we;
    logic user;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

//--- sra_mem.sv
/*
  Small synchronous byte memory standing in for the register space or
  the user store. Read data is registered.
  Assumes one access per clock from the serial slave.
*/
`timescale 1ns/10ps
module sra_mem #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  // Contents survive loss of main supply, so no reset here
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

//--- sra_slave_properties.sv
/* Port assertions for the two-wire register access slave.
   Assumes binding to sra_slave with its mclk as the only clock. */
`timescale 1ns/10ps
module sra_slave_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic backup,
  input wire logic sda_out,
  input wire logic sda_oe_b,
  input wire sra_pkg::reg_req_s wr_req,
  input wire logic wr_strobe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  rst_quiet_a: assert property (
    $rose(rst_b) |-> sda_oe_b && !wr_strobe) else $error("not idle");
  strobe_pulse_a: assert property (
    wr_strobe |=> !wr_strobe) else $error("long strobe");
  backup_idle_a: assert property (
    backup [*6] |-> sda_oe_b && !wr_strobe) else $error("active");
  drive_low_a: assert property (
    !sda_oe_b |-> !sda_out) else $error("drives high");
  change_low_a: assert property (
    $changed(sda_oe_b) |-> !scl) else $error("sda moved");
  strobe_ack_a: assert property (
    wr_strobe |-> ##[0:6] !sda_oe_b) else $error("no data ack");
  strobe_we_a: assert property (
    wr_strobe |-> wr_req.we) else $error("not a write");
  strobe_low_a: assert property (
    wr_strobe |-> !scl) else $error("strobe scl high");
  cover property (wr_strobe);
  cover property ($fell(sda_oe_b));
  cover property (backup [*4]);
endmodule
bind sra_slave sra_slave_props chk (.mclk, .rst_b, .scl, .sda_in,
  .backup, .sda_out, .sda_oe_b, .wr_req, .wr_strobe);

//--- sra_master.sv
/* Two-wire bus master model driving scl and its pull on sda.
   Assumes a pull-up, so sda_bus is high unless a party pulls it. */
`timescale 1ns/10ps
module sra_master (
  input wire logic mclk,
  input wire logic sda_bus,
  output logic scl = 1'h1,
  output logic sda = 1'h1
);
  task automatic tick();
    repeat (4) @(posedge mclk);
  endtask
  // Serves as repeated start too
  task automatic start();
    sda <= 1'h1;
    tick();
    scl <= 1'h1;
    tick();
    sda <= 1'h0;
    tick();
    scl <= 1'h0;
    tick();
  endtask
  task automatic stop();
    sda <= 1'h0;
    tick();
    scl <= 1'h1;
    tick();
    sda <= 1'h1;
    tick();
  endtask
  // Nine clocks; sda moves mid-low to keep clear of the slave's lag
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda <= tx[i];
      tick();
      scl <= 1'h1;
      tick();
      rx[i] = sda_bus;
      scl <= 1'h0;
      tick();
    end
  endtask
endmodule

//--- sra_slave_test.sv
/* Self-checking bench for the two-wire register access slave.
   Assumes the master model and the bound property checker. */
`timescale 1ns/10ps
module sra_slave_test;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic backup = 1'h0;
  logic scl;
  logic m_sda;
  logic sda_out;
  logic sda_oe_b;
  logic wr_strobe;
  logic [8:0] rx;
  sra_pkg::reg_req_s wr_req;
  sra_pkg::reg_req_s last_req;
  int err_total = 0;
  int samples_checked = 0;
  int strobes = 0;
  int cyc = 0;
  wire sda_bus = m_sda & (sda_oe_b | sda_out);
  always #25 mclk = ~mclk;
  sra_slave dut (.mclk, .rst_b, .scl, .sda_in(sda_bus), .backup,
    .sda_out, .sda_oe_b, .wr_req, .wr_strobe);
  sra_master mst (.mclk, .sda_bus, .scl, .sda(m_sda));
  always @(posedge mclk) begin
    cyc++;
    if (wr_strobe === 1'h1) begin
      strobes++;
      last_req = wr_req;
    end
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'h1) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic put(input logic [7:0] b, input logic ack, string m);
    mst.bits({b, 1'h1}, rx);
    chk(rx[0] === !ack, m);
  endtask
  task automatic get(input logic [7:0] e, input logic last);
    mst.bits({8'hFF, last}, rx);
    chk(rx[8:1] === e, "read data");
  endtask
  task automatic wr(input logic [6:0] id, input logic [7:0] a, d);
    int n;
    n = strobes;
    mst.start();
    put({id, 1'h0}, 1'h1, "id ack");
    put(a, 1'h1, "addr ack");
    put(d, 1'h1, "data ack");
    mst.stop();
    chk(strobes == n + 1, "strobe count");
    chk(last_req === {1'h1, id == sra_pkg::ID_USER, a, d}, "req");
  endtask
  task automatic rd(input logic [6:0] id, input logic [7:0] a, e0, e1);
    mst.start();
    put({id, 1'h0}, 1'h1, "id ack");
    put(a, 1'h1, "addr ack");
    mst.start();
    put({id, 1'h1}, 1'h1, "read id ack");
    get(e0, 1'h0);
    get(e1, 1'h1);
    mst.stop();
  endtask
  task automatic test_csr();
    wr(sra_pkg::ID_CSR, sra_pkg::CSR_LAST, 8'h3C);
    wr(sra_pkg::ID_CSR, 8'h00, 8'hC3);
    rd(sra_pkg::ID_CSR, sra_pkg::CSR_LAST, 8'h3C, 8'hC3);
    $display("csr write and wrapping read done");
  endtask
  task automatic test_user();
    wr(sra_pkg::ID_USER, sra_pkg::USER_LAST, 8'h11);
    wr(sra_pkg::ID_USER, 8'h00, 8'h22);
    rd(sra_pkg::ID_USER, sra_pkg::USER_LAST, 8'h11, 8'h22);
    $display("user store done");
  endtask
  task automatic test_bad_id();
    int n;
    n = strobes;
    mst.start();
    put({sra_pkg::ID_CSR ^ 7'h01, 1'h0}, 1'h0, "foreign id");
    put(8'h05, 1'h0, "ignored addr");
    put(8'h99, 1'h0, "ignored data");
    mst.stop();
    chk(strobes == n, "foreign write");
    rd(sra_pkg::ID_CSR, sra_pkg::CSR_LAST, 8'h3C, 8'hC3);
    $display("foreign id done");
  endtask
  task automatic test_backup();
    backup <= 1'h1;
    mst.tick();
    mst.start();
    put({sra_pkg::ID_CSR, 1'h0}, 1'h0, "backup id");
    mst.stop();
    backup <= 1'h0;
    mst.tick();
    wr(sra_pkg::ID_CSR, 8'h00, 8'hC3);
    rd(sra_pkg::ID_CSR, sra_pkg::CSR_LAST, 8'h3C, 8'hC3);
    $display("backup done");
  endtask
  // Store has no reset, so 00h still holds C3 after a mid-run reset
  task automatic test_power_up();
    rst_b <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    repeat (4) @(posedge mclk);
    mst.start();
    put({sra_pkg::ID_CSR, 1'h1}, 1'h1, "current read id");
    get(8'hC3, 1'h1);
    mst.stop();
    $display("power-up pointer done");
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    repeat (4) @(posedge mclk);
    test_csr();
    test_user();
    test_bad_id();
    test_backup();
    test_power_up();
    stop_test();
  end
endmodule
